// ### core/cod_defs.svh
// Constants for the clock output driver control bank.
// Assumes byte-wide registers reached by a decoded register port.
`ifndef COD_DEFS_SVH
`define COD_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define COD_ADDR_CTL_0      16'h00f0
`define COD_ADDR_CTL_1      16'h00f1
`define COD_NUM_OUTPUTS     2

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define COD_FMT_BIT         7
`define COD_HALF_SECOND_BIT 6
`define COD_HALF_FIRST_BIT  5
`define COD_POL_HI_BIT      4
`define COD_POL_LO_BIT      3
`define COD_SWING_HI_BIT    2
`define COD_SWING_LO_BIT    1
`define COD_PD_BIT          0

// ----------------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------------
`define COD_CTL_RESET       8'h04
`define COD_RDATA_UNMAPPED  8'h00
`define COD_SINGLE_ENDED    1'h1
`define COD_SWING_400MV     2'h0
`define COD_SWING_600MV     2'h1
`define COD_SWING_DEFAULT   2'h2
`define COD_SWING_960MV     2'h3

`endif

// ### core/cod_pkg.sv
// Types for the clock output driver control bank.
// Assumes cod_defs.svh supplies the widths and counts.
`include "cod_defs.svh"

package cod_pkg;

  // --------------------------------------------------------------------------
  // Register and decoded driver controls
  // --------------------------------------------------------------------------
  typedef logic [7:0] cod_ctl_type;

  typedef struct packed {
    logic       single_ended;
    logic       diff_active;
    logic       diff_power_down;
    logic [1:0] swing;
    logic       first_en;
    logic       second_en;
    logic       first_inv;
    logic       second_inv;
  } cod_drive_type;

  // --------------------------------------------------------------------------
  // Whole state of the top module
  // --------------------------------------------------------------------------
  typedef struct packed {
    cod_ctl_type   [`COD_NUM_OUTPUTS-1:0] ctl;
    cod_drive_type [`COD_NUM_OUTPUTS-1:0] drive;
    logic          [7:0]                  rdata;
    logic                                 rd_valid;
  } cod_state_type;

endpackage : cod_pkg

// ### core/cod_driver_decode.sv
// Decoder from one output control byte to static driver controls.
// Assumes a registered control byte; purely combinational.
`timescale 1ns/1ns
`include "cod_defs.svh"

module cod_driver_decode (
  // Control byte
  input  wire cod_pkg::cod_ctl_type   ctl,
  // Driver controls
  output cod_pkg::cod_drive_type      drive
);
  import cod_pkg::*;

  logic se;
  logic pol_hi;
  logic pol_lo;

  assign se     = (ctl[`COD_FMT_BIT] == `COD_SINGLE_ENDED);
  assign pol_hi = ctl[`COD_POL_HI_BIT];
  assign pol_lo = ctl[`COD_POL_LO_BIT];

  always_comb begin
    drive.single_ended    = se;
    // Half field means nothing in differential format
    drive.first_en        = se & ctl[`COD_HALF_FIRST_BIT];
    drive.second_en       = se & ctl[`COD_HALF_SECOND_BIT];
    // First half inverts on bit 3 in both formats
    drive.first_inv       = pol_lo;
    if (se) begin
      drive.second_inv    = pol_hi ^ pol_lo;
    end else begin
      drive.second_inv    = ~pol_lo;
    end
    drive.swing           = ctl[`COD_SWING_HI_BIT:`COD_SWING_LO_BIT];
    drive.diff_power_down = ctl[`COD_PD_BIT];
    drive.diff_active     = ~se & ~ctl[`COD_PD_BIT];
  end

endmodule : cod_driver_decode

// ### core/cod_top.sv
// Control bank for two clock output drivers: registers and decode.
// Assumes a decoded register port from the serial control logic, same clock.
//
// Operation
// - In single-ended format, bits 6:5 enable the second and first halves, a cleared bit tristating that half.
// - In differential format bit 4 is ignored and bit 3 swaps the inverting and noninverting halves.
// - In single-ended format bits 4:3 pick both-noninverting, both-inverting, second-inverting or first-inverting.
// - Bit 0 set places the differential driver in safe power-down, cleared lets it run normally in differential format.
// - The second output's register has the first one's layout and acts only on the second driver.
`timescale 1ns/1ns
`include "cod_defs.svh"

module cod_top #(
  parameter int ADDR_WIDTH = 10
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register port
  input  wire logic                  reg_wr_en,
  input  wire logic                  reg_rd_en,
  input  wire logic [ADDR_WIDTH-1:0] reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  output logic                       reg_rd_valid,
  // First clock output driver
  output logic                       clock_output_zero_single_ended,
  output logic                       clock_output_zero_diff_active,
  output logic                       clock_output_zero_diff_power_down,
  output logic      [1:0]            clock_output_zero_differential_swing,
  output logic                       clock_output_zero_first_single_ended_half_en,
  output logic                       clock_output_zero_second_single_ended_half_en,
  output logic                       clock_output_zero_first_single_ended_half_inv,
  output logic                       clock_output_zero_second_single_ended_half_inv,
  // Second clock output driver
  output logic                       clock_output_one_single_ended,
  output logic                       clock_output_one_diff_active,
  output logic                       clock_output_one_diff_power_down,
  output logic      [1:0]            clock_output_one_differential_swing,
  output logic                       clock_output_one_first_single_ended_half_en,
  output logic                       clock_output_one_second_single_ended_half_en,
  output logic                       clock_output_one_first_single_ended_half_inv,
  output logic                       clock_output_one_second_single_ended_half_inv
);
  import cod_pkg::*;

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  // Offsets need eight bits; wider than sixteen cannot be compared
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 16) begin : g_bad_width
    $error("cod_top: ADDR_WIDTH must lie in 8..16");
  end

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  localparam logic [15:0] CTL_ADDR [`COD_NUM_OUTPUTS] = '{`COD_ADDR_CTL_0, `COD_ADDR_CTL_1};

  logic [15:0]                 addr_ext;
  logic [`COD_NUM_OUTPUTS-1:0] hit;
  cod_drive_type               drive_dec [`COD_NUM_OUTPUTS];
  cod_state_type               state;
  cod_state_type               next_state;

  assign addr_ext = {{(16-ADDR_WIDTH){1'b0}}, reg_addr};

  // Same layout per output, each decoder fed only by its own byte
  for (genvar i = 0; i < `COD_NUM_OUTPUTS; i++) begin : g_out
    assign hit[i] = (addr_ext == CTL_ADDR[i]);
    cod_driver_decode u_decode (
      .ctl   (state.ctl[i]),
      .drive (drive_dec[i])
    );
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_state          = state;
    next_state.rd_valid = 1'b0;
    // Read sees the value before a same-cycle write
    if (reg_rd_en) begin
      next_state.rd_valid = 1'b1;
      next_state.rdata    = `COD_RDATA_UNMAPPED;
      for (int i = 0; i < `COD_NUM_OUTPUTS; i++) begin
        if (hit[i]) begin
          next_state.rdata = state.ctl[i];
        end
      end
    end
    // Writes to other offsets are dropped silently
    if (reg_wr_en) begin
      for (int i = 0; i < `COD_NUM_OUTPUTS; i++) begin
        if (hit[i]) begin
          next_state.ctl[i] = reg_wdata;
        end
      end
    end
    // Registered decode costs a cycle but keeps driver pins glitch free
    for (int i = 0; i < `COD_NUM_OUTPUTS; i++) begin
      next_state.drive[i] = drive_dec[i];
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `COD_NUM_OUTPUTS; i++) begin
        state.ctl[i]                   <= `COD_CTL_RESET;
        state.drive[i].single_ended    <= 1'b0;
        state.drive[i].diff_active     <= 1'b1;
        state.drive[i].diff_power_down <= 1'b0;
        state.drive[i].swing           <= `COD_SWING_DEFAULT;
        state.drive[i].first_en        <= 1'b0;
        state.drive[i].second_en       <= 1'b0;
        state.drive[i].first_inv       <= 1'b0;
        state.drive[i].second_inv      <= 1'b1;
      end
      state.rdata    <= 8'h00;
      state.rd_valid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign reg_rdata    = state.rdata;
  assign reg_rd_valid = state.rd_valid;

  assign clock_output_zero_single_ended                 = state.drive[0].single_ended;
  assign clock_output_zero_diff_active                  = state.drive[0].diff_active;
  assign clock_output_zero_diff_power_down              = state.drive[0].diff_power_down;
  assign clock_output_zero_differential_swing           = state.drive[0].swing;
  assign clock_output_zero_first_single_ended_half_en   = state.drive[0].first_en;
  assign clock_output_zero_second_single_ended_half_en  = state.drive[0].second_en;
  assign clock_output_zero_first_single_ended_half_inv  = state.drive[0].first_inv;
  assign clock_output_zero_second_single_ended_half_inv = state.drive[0].second_inv;

  assign clock_output_one_single_ended                  = state.drive[1].single_ended;
  assign clock_output_one_diff_active                   = state.drive[1].diff_active;
  assign clock_output_one_diff_power_down               = state.drive[1].diff_power_down;
  assign clock_output_one_differential_swing            = state.drive[1].swing;
  assign clock_output_one_first_single_ended_half_en    = state.drive[1].first_en;
  assign clock_output_one_second_single_ended_half_en   = state.drive[1].second_en;
  assign clock_output_one_first_single_ended_half_inv   = state.drive[1].first_inv;
  assign clock_output_one_second_single_ended_half_inv  = state.drive[1].second_inv;

endmodule : cod_top

// ### verif/cod_top_monitor.sv
// Checker for the driver control bank, bound to cod_top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`include "cod_defs.svh"
module cod_top_monitor #(
  parameter int ADDR_WIDTH = 10
) (
  input wire logic                  clk, rst, reg_wr_en, reg_rd_en, reg_rd_valid,
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic [7:0]            reg_wdata, reg_rdata,
  input wire logic                  clock_output_zero_single_ended, clock_output_zero_diff_active,
  input wire logic                  clock_output_zero_diff_power_down, clock_output_one_single_ended,
  input wire logic                  clock_output_zero_first_single_ended_half_en,
  input wire logic                  clock_output_zero_second_single_ended_half_en,
  input wire logic                  clock_output_zero_first_single_ended_half_inv,
  input wire logic                  clock_output_zero_second_single_ended_half_inv,
  input wire logic [1:0]            clock_output_zero_differential_swing, clock_output_one_differential_swing
);
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Outputs show a write two edges later; the cycle in between must carry no second write to the same register
  wire w0  = reg_wr_en && reg_addr == ADDR_WIDTH'(`COD_ADDR_CTL_0);
  wire w1  = reg_wr_en && reg_addr == ADDR_WIDTH'(`COD_ADDR_CTL_1);
  wire gap = reg_addr != ADDR_WIDTH'(`COD_ADDR_CTL_0) && reg_addr != ADDR_WIDTH'(`COD_ADDR_CTL_1);
  property p_half_en;
    w0 ##1 !w0 |=> clock_output_zero_first_single_ended_half_en == $past(reg_wdata[7] & reg_wdata[5], 2) &&
      clock_output_zero_second_single_ended_half_en == $past(reg_wdata[7] & reg_wdata[6], 2);
  endproperty
  a_half_en: assert property (p_half_en) else $error("half enable differs from byte");
  property p_diff_pol;
    w0 && !reg_wdata[7] ##1 !w0 |=> clock_output_zero_first_single_ended_half_inv == $past(reg_wdata[3], 2) &&
      clock_output_zero_second_single_ended_half_inv != clock_output_zero_first_single_ended_half_inv;
  endproperty
  a_diff_pol: assert property (p_diff_pol) else $error("differential polarity wrong");
  property p_se_pol;
    w0 && reg_wdata[7] ##1 !w0 |=> {clock_output_zero_first_single_ended_half_inv,
      clock_output_zero_second_single_ended_half_inv} == $past({reg_wdata[3], ^reg_wdata[4:3]}, 2);
  endproperty
  a_se_pol: assert property (p_se_pol) else $error("single-ended polarity wrong");
  property p_pd_swing;
    w0 ##1 !w0 |=> clock_output_zero_diff_power_down == $past(reg_wdata[0], 2) &&
      clock_output_zero_diff_active == !$past(reg_wdata[7] | reg_wdata[0], 2) &&
      clock_output_zero_differential_swing == $past(reg_wdata[2:1], 2);
  endproperty
  a_pd_swing: assert property (p_pd_swing) else $error("power-down or swing wrong");
  property p_one;
    w1 ##1 !w1 |=> {clock_output_one_single_ended, clock_output_one_differential_swing} ==
      $past({reg_wdata[7], reg_wdata[2:1]}, 2);
  endproperty
  a_one: assert property (p_one) else $error("second output decode wrong");
  property p_iso;
    !w0 ##1 !w0 |=> $stable({clock_output_zero_single_ended, clock_output_zero_diff_power_down,
      clock_output_zero_differential_swing});
  endproperty
  a_iso: assert property (p_iso) else $error("first output moved without its write");
  property p_swing_rst;
    $fell(rst) |-> clock_output_zero_differential_swing == `COD_SWING_DEFAULT &&
      clock_output_one_differential_swing == `COD_SWING_DEFAULT;
  endproperty
  a_swing_rst: assert property (p_swing_rst) else $error("swing not default after reset");
  property p_rd_gap;
    reg_rd_en && gap |=> reg_rd_valid && reg_rdata == `COD_RDATA_UNMAPPED;
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not zero");
endmodule : cod_top_monitor
bind cod_top cod_top_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) cod_top_monitor_inst (.*);

// ### verif/cod_top_tb_top.sv
// Self-checking bench for the driver control bank.
// Assumes cod_top with its checker bound in; inputs move on falling edges.
`timescale 1ns/1ns
`include "cod_defs.svh"
module cod_top_tb_top;
  import cod_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_valid;
  logic [9:0]  addr = 10'h000;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [7:0]  mem [2];
  wire  [8:0]  z, o;
  logic [7:0]  old_byte;
  logic [31:0] seed = 32'h4ab0929d;
  int          fail_count = 0, check_count = 0;
  always #5 clk = ~clk;
  cod_top #(.ADDR_WIDTH(10)) cod_top_inst (
    .clk(clk), .rst(rst), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rd_valid(rd_valid),
    .clock_output_zero_single_ended(z[8]), .clock_output_zero_diff_active(z[7]),
    .clock_output_zero_diff_power_down(z[6]), .clock_output_zero_differential_swing(z[5:4]),
    .clock_output_zero_first_single_ended_half_en(z[3]), .clock_output_zero_second_single_ended_half_en(z[2]),
    .clock_output_zero_first_single_ended_half_inv(z[1]), .clock_output_zero_second_single_ended_half_inv(z[0]),
    .clock_output_one_single_ended(o[8]), .clock_output_one_diff_active(o[7]),
    .clock_output_one_diff_power_down(o[6]), .clock_output_one_differential_swing(o[5:4]),
    .clock_output_one_first_single_ended_half_en(o[3]), .clock_output_one_second_single_ended_half_en(o[2]),
    .clock_output_one_first_single_ended_half_inv(o[1]), .clock_output_one_second_single_ended_half_inv(o[0]));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected driver controls, in the same order as z and o
  function automatic logic [8:0] drive_of(input logic [7:0] b);
    drive_of = {b[7], ~b[7] & ~b[0], b[0], b[2:1], b[7] & b[5], b[7] & b[6], b[3], b[7] ? ^b[4:3] : ~b[3]};
  endfunction : drive_of
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    if (a == 10'h0f0 || a == 10'h0f1) mem[a[0]] = d;
    @(negedge clk) wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [9:0] a, input logic [7:0] exp);
    rd = 1'b1;
    addr = a;
    @(negedge clk) rd = 1'b0;
    check("read valid", 9'h001, {8'h00, rd_valid});
    check("read data", {1'b0, exp}, {1'b0, rdata});
  endtask : rd_reg
  // Decode is registered, so outputs settle one edge after the write
  task automatic check_outs();
    @(negedge clk);
    check("output zero", drive_of(mem[0]), z);
    check("output one", drive_of(mem[1]), o);
  endtask : check_outs
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    mem[0] = `COD_CTL_RESET;
    mem[1] = `COD_CTL_RESET;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check_outs();
    rd_reg(10'h0f1, `COD_CTL_RESET);
    $display("Test reset done");
    for (int i = 0; i < 64; i++) begin
      wr_reg({9'h078, i[5]}, {i[4:0], i[1:0], i[3]});
      check_outs();
    end
    $display("Test field table done");
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      wr_reg({9'h078, seed[8]}, seed[7:0]);
      if (!seed[9]) check_outs();
      rd_reg({9'h078, seed[10]}, mem[seed[10]]);
    end
    $display("Test random traffic done");
    // Read and write of one register in one cycle: the read returns the old byte
    old_byte = mem[0];
    rd = 1'b1;
    wr_reg(10'h0f0, 8'h5a);
    rd = 1'b0;
    check("read before write", {1'b1, old_byte}, {rd_valid, rdata});
    check_outs();
    check("read valid drop", 9'h000, {8'h00, rd_valid});
    $display("Test read with write done");
    wr_reg(10'h0f2, 8'hff);
    check_outs();
    rd_reg(10'h0f2, `COD_RDATA_UNMAPPED);
    rd_reg(10'h3ff, `COD_RDATA_UNMAPPED);
    $display("Test unmapped done");
    rst = 1'b1;
    @(negedge clk) rst = 1'b0;
    mem[0] = `COD_CTL_RESET;
    mem[1] = `COD_CTL_RESET;
    check_outs();
    $display("Test second reset done");
    results();
  end
endmodule : cod_top_tb_top
